// ### hdl/swrs_pkg.sv
// Constants, types and register map for the SIMD shift datapath.
// Assumes a single core clock and an APB master for software access.
// Notes on behaviour
// - Widening result elements are double source width.
// - Widening field top bits zero: related encodings.
// - Field 001xxx: 8-bit, eight elements, minus 8.
// - Field 01xxxx: 16-bit, four elements, minus 16.
// - Field 1xxxxx: 32-bit, two elements, minus 32.
// - Zero widening shift decodes as widening move.
// - Variable widening form: odd destination is undefined.
// - Maximum form: size 11 or odd destination undefined.
// - Maximum form shifts by element width, signless.
// - Variable form: bit clear signed, set unsigned.
// - Extend per signedness, shift left, keep double width.
// - Constant-time: latency independent of data and flags.
// - Constant-time: exception response independent of data.
// - Access controls make execution undefined or trapped.
// - Right shift keeps size and truncates, no rounding.
// - Combined field 0000xxx goes to related encodings.
// - Quadword right shift: odd index undefined, two registers.
// - Combined 0001xxx: 8-bit, shift 16 minus field.
// - Combined 001xxxx: 16-bit, shift 32 minus field.
// - Combined 01xxxxx: 32-bit, shift 64 minus field.
// - Combined 1xxxxxx: 64-bit, shift 64 minus field.
// - Right shift per element, store low element bits.
package swrs_pkg;

  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DREG_W     = 64;
  localparam int unsigned QREG_W     = 128;
  localparam int unsigned NUM_DREGS  = 32;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned SH_W       = 7;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_INDEX  = 12'h008;
  localparam logic [11:0] OFF_DLO    = 12'h00C;
  localparam logic [11:0] OFF_DHI    = 12'h010;

  // Control fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_TRAP_BIT = 1;
  localparam int unsigned CTRL_CT_BIT   = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;

  // Status fields
  localparam int unsigned ST_UNDEF_BIT   = 0;
  localparam int unsigned ST_TRAP_BIT    = 1;
  localparam int unsigned ST_RELATED_BIT = 2;
  localparam int unsigned ST_WMOVE_BIT   = 3;
  localparam int unsigned ST_EXEC_BIT    = 4;

  // Element sizes and shift bases
  localparam logic [6:0] ESZ_8   = 7'h08;
  localparam logic [6:0] ESZ_16  = 7'h10;
  localparam logic [6:0] ESZ_32  = 7'h20;
  localparam logic [6:0] ESZ_64  = 7'h40;
  localparam logic [1:0] SIZE_BAD = 2'h3;
  localparam logic [6:0] ZERO_SH = 7'h00;

  typedef enum logic [1:0] {
    SWRS_OP_WIDEN_VAR,
    SWRS_OP_WIDEN_MAX,
    SWRS_OP_RIGHT
  } swrs_op_e;

  typedef enum logic [2:0] {
    SWRS_RES_EXEC,
    SWRS_RES_UNDEF,
    SWRS_RES_TRAP,
    SWRS_RES_RELATED,
    SWRS_RES_WMOVE
  } swrs_res_e;

  typedef struct packed {
    logic       valid;
    swrs_op_e   op;
    logic       cond_pass;
    logic [3:0] condition_flags;
    logic       unsigned_bit;
    logic       d_hi;
    logic [3:0] dest_register_index;
    logic       m_hi;
    logic [3:0] source_register_index;
    logic       long_bit;
    logic       quad_bit;
    logic [5:0] shift_field_six_bit;
    logic [1:0] size_field;
  } swrs_instr_s;

  typedef struct packed {
    swrs_res_e       res;
    logic            uns;
    logic            quad;
    logic [6:0]      esz;
    logic [6:0]      shamt;
    logic [IDX_W-1:0] d;
    logic [IDX_W-1:0] m;
  } swrs_dec_s;

endpackage

// ### hdl/swrs_shift_unit.sv
// Widening left shift and truncating right shift datapath with decode.
// Assumes instruction fields arrive from decode on pclk; APB for software.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module swrs_shift_unit #(
  parameter int unsigned NREGS = swrs_pkg::NUM_DREGS
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [swrs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [swrs_pkg::DATA_W-1:0] pwdata,
  output logic      [swrs_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Instruction from decode stage
  input  wire swrs_pkg::swrs_instr_s       instr,
  // Completion to decode stage
  output logic                             done,
  output swrs_pkg::swrs_res_e              result_kind
);

  logic [2:0]                   ctrl_reg;
  logic [4:0]                   status_reg;
  logic [swrs_pkg::IDX_W-1:0]   index_reg;
  logic [swrs_pkg::DREG_W-1:0]  dreg_reg [NREGS];
  logic                         done_reg;
  swrs_pkg::swrs_res_e          kind_reg;
  logic [swrs_pkg::DATA_W-1:0]  prdata_reg;
  logic                         pready_reg;
  logic                         pslverr_reg;

  // Decoding of the two shift families
  function automatic swrs_pkg::swrs_dec_s decode(
    input swrs_pkg::swrs_instr_s i
  );
    swrs_pkg::swrs_dec_s r;
    logic [6:0] f;
    r = '0;
    f = {1'b0, i.shift_field_six_bit};
    r.d = {i.d_hi, i.dest_register_index};
    r.m = {i.m_hi, i.source_register_index};
    r.res = swrs_pkg::SWRS_RES_EXEC;
    case (i.op)
      swrs_pkg::SWRS_OP_WIDEN_VAR:
      begin
        r.uns = i.unsigned_bit;
        if (f[5])
        begin
          r.esz = swrs_pkg::ESZ_32;
          r.shamt = 7'(f - swrs_pkg::ESZ_32);
        end
        else if (f[4])
        begin
          r.esz = swrs_pkg::ESZ_16;
          r.shamt = 7'(f - swrs_pkg::ESZ_16);
        end
        else
        begin
          r.esz = swrs_pkg::ESZ_8;
          r.shamt = 7'(f - swrs_pkg::ESZ_8);
        end
        if (f[5:3] == 3'h0)
          r.res = swrs_pkg::SWRS_RES_RELATED;
        else if (i.dest_register_index[0])
          r.res = swrs_pkg::SWRS_RES_UNDEF;
        else if (r.shamt == swrs_pkg::ZERO_SH)
          r.res = swrs_pkg::SWRS_RES_WMOVE;
      end
      swrs_pkg::SWRS_OP_WIDEN_MAX:
      begin
        // Signedness cannot matter: all extension bits shift out
        r.uns = 1'b0;
        r.esz = 7'(swrs_pkg::ESZ_8 << i.size_field);
        r.shamt = r.esz;
        if (i.size_field == swrs_pkg::SIZE_BAD
            || i.dest_register_index[0])
          r.res = swrs_pkg::SWRS_RES_UNDEF;
      end
      default:
      begin
        r.uns = i.unsigned_bit;
        r.quad = i.quad_bit;
        if (i.long_bit)
        begin
          r.esz = swrs_pkg::ESZ_64;
          r.shamt = 7'(swrs_pkg::ESZ_64 - f);
        end
        else if (f[5])
        begin
          r.esz = swrs_pkg::ESZ_32;
          r.shamt = 7'(swrs_pkg::ESZ_64 - f);
        end
        else if (f[4])
        begin
          r.esz = swrs_pkg::ESZ_16;
          r.shamt = 7'(swrs_pkg::ESZ_32 - f);
        end
        else
        begin
          r.esz = swrs_pkg::ESZ_8;
          r.shamt = 7'(swrs_pkg::ESZ_16 - f);
        end
        if (!i.long_bit && f[5:3] == 3'h0)
          r.res = swrs_pkg::SWRS_RES_RELATED;
        else if (i.quad_bit && (i.dest_register_index[0]
                 || i.source_register_index[0]))
          r.res = swrs_pkg::SWRS_RES_UNDEF;
      end
    endcase
    return r;
  endfunction

  // Sign or zero extend the element at position e to 64 bits
  function automatic logic [63:0] extend(
    input logic [63:0] src,
    input int          e,
    input int          esz,
    input logic        uns
  );
    logic [63:0] t;
    t = src >> (e * esz);
    t = t << (64 - esz);
    if (uns)
      extend = t >> (64 - esz);
    else
      extend = $signed(t) >>> (64 - esz);
  endfunction

  function automatic logic [63:0] low_mask(input int w);
    if (w >= 64)
      low_mask = '1;
    else
      low_mask = (64'h0000_0000_0000_0001 << w) - 64'h0000_0000_0000_0001;
  endfunction

  // Widening left shift of one doubleword into one quadword
  function automatic logic [127:0] widen(
    input logic [63:0] src,
    input swrs_pkg::swrs_dec_s dc
  );
    logic [127:0] r;
    logic [63:0]  v;
    int           esz;
    r = '0;
    esz = int'(dc.esz);
    for (int e = 0; e < 8; e++)
    begin
      if (e * esz < 64)
      begin
        v = extend(src, e, esz, dc.uns) << dc.shamt;
        r = r | (128'(v & low_mask(2 * esz)) << (e * 2 * esz));
      end
    end
    return r;
  endfunction

  // Truncating right shift of one doubleword, same element size
  function automatic logic [63:0] rshift(
    input logic [63:0] src,
    input swrs_pkg::swrs_dec_s dc
  );
    logic [63:0] r;
    logic [63:0] v;
    int          esz;
    r = '0;
    esz = int'(dc.esz);
    for (int e = 0; e < 8; e++)
    begin
      if (e * esz < 64)
      begin
        v = extend(src, e, esz, dc.uns);
        // No rounding bit is added; shifted-out bits are lost
        if (dc.uns)
          v = v >> dc.shamt;
        else
          v = $signed(v) >>> dc.shamt;
        r = r | ((v & low_mask(esz)) << (e * esz));
      end
    end
    return r;
  endfunction

  swrs_pkg::swrs_dec_s dec;
  logic                issue;
  logic                blocked;
  logic                run;
  logic [127:0]        wide_res;
  logic [63:0]         rs_lo;
  logic [63:0]         rs_hi;
  logic                apb_go;
  logic                apb_wr;

  assign dec = decode(instr);
  assign issue = instr.valid && instr.cond_pass;
  assign blocked = !ctrl_reg[swrs_pkg::CTRL_EN_BIT]
                   || ctrl_reg[swrs_pkg::CTRL_TRAP_BIT];
  assign run = issue && !blocked && dec.res == swrs_pkg::SWRS_RES_EXEC;
  assign wide_res = widen(dreg_reg[dec.m], dec);
  assign rs_lo = rshift(dreg_reg[dec.m], dec);
  assign rs_hi = rshift(dreg_reg[5'(dec.m + 5'h01)], dec);
  assign apb_go = psel && penable && pready_reg;
  assign apb_wr = apb_go && pwrite;

  // Completion: always one cycle after issue, whatever the data or flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_reg <= 1'b0;
      kind_reg <= swrs_pkg::SWRS_RES_EXEC;
    end
    else
    begin
      done_reg <= issue;
      if (issue)
      begin
        if (!ctrl_reg[swrs_pkg::CTRL_EN_BIT])
          kind_reg <= swrs_pkg::SWRS_RES_UNDEF;
        else if (ctrl_reg[swrs_pkg::CTRL_TRAP_BIT])
          kind_reg <= swrs_pkg::SWRS_RES_TRAP;
        else
          kind_reg <= dec.res;
      end
    end
  end

  // Sticky-free status of the most recent issue
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= '0;
    else if (issue)
    begin
      status_reg <= '0;
      status_reg[swrs_pkg::ST_UNDEF_BIT] <=
        !ctrl_reg[swrs_pkg::CTRL_EN_BIT]
        || (!blocked && dec.res == swrs_pkg::SWRS_RES_UNDEF);
      status_reg[swrs_pkg::ST_TRAP_BIT] <=
        ctrl_reg[swrs_pkg::CTRL_EN_BIT] && ctrl_reg[swrs_pkg::CTRL_TRAP_BIT];
      status_reg[swrs_pkg::ST_RELATED_BIT] <=
        !blocked && dec.res == swrs_pkg::SWRS_RES_RELATED;
      status_reg[swrs_pkg::ST_WMOVE_BIT] <=
        !blocked && dec.res == swrs_pkg::SWRS_RES_WMOVE;
      status_reg[swrs_pkg::ST_EXEC_BIT] <= run;
    end
  end

  // Register file; an executing write wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < NREGS; k++)
        dreg_reg[k] <= '0;
    end
    else if (run && instr.op != swrs_pkg::SWRS_OP_RIGHT)
    begin
      dreg_reg[{dec.d[4:1], 1'b0}] <= wide_res[63:0];
      dreg_reg[{dec.d[4:1], 1'b1}] <= wide_res[127:64];
    end
    else if (run)
    begin
      dreg_reg[dec.d] <= rs_lo;
      if (dec.quad)
        dreg_reg[5'(dec.d + 5'h01)] <= rs_hi;
    end
    else if (apb_wr && paddr == swrs_pkg::OFF_DLO)
      dreg_reg[index_reg][31:0] <= pwdata;
    else if (apb_wr && paddr == swrs_pkg::OFF_DHI)
      dreg_reg[index_reg][63:32] <= pwdata;
  end

  // Software control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg  <= swrs_pkg::CTRL_RESET;
      index_reg <= '0;
    end
    else if (apb_wr)
    begin
      if (paddr == swrs_pkg::OFF_CTRL)
        ctrl_reg <= pwdata[2:0];
      else if (paddr == swrs_pkg::OFF_INDEX)
        index_reg <= pwdata[swrs_pkg::IDX_W-1:0];
    end
  end

  // APB: one wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
      if (psel && penable && !pready_reg)
      begin
        if (paddr == swrs_pkg::OFF_CTRL)
          prdata_reg <= 32'(ctrl_reg);
        else if (paddr == swrs_pkg::OFF_STATUS)
          prdata_reg <= 32'(status_reg);
        else if (paddr == swrs_pkg::OFF_INDEX)
          prdata_reg <= 32'(index_reg);
        else if (paddr == swrs_pkg::OFF_DLO)
          prdata_reg <= dreg_reg[index_reg][31:0];
        else if (paddr == swrs_pkg::OFF_DHI)
          prdata_reg <= dreg_reg[index_reg][63:32];
        else
          pslverr_reg <= 1'b1;
      end
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign done        = done_reg;
  assign result_kind = kind_reg;

endmodule

// ### dv/swrs_shift_assertions.sv
// Checker: decode outcomes, issue latency and bus wait state.
// Assumes it is bound to swrs_shift_unit and sees its ports only.
`timescale 1ns/1ps
module swrs_shift_assertions #(
  parameter int unsigned NREGS = swrs_pkg::NUM_DREGS
) (
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [swrs_pkg::ADDR_W-1:0] paddr,
  input wire logic [swrs_pkg::DATA_W-1:0] pwdata,
  input wire logic [swrs_pkg::DATA_W-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Instruction side
  input wire swrs_pkg::swrs_instr_s       instr,
  input wire logic                        done,
  input wire swrs_pkg::swrs_res_e         result_kind
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic iss, wv, rt, wtop, rtop, refd, odd;
  assign iss  = instr.valid && instr.cond_pass;
  assign wv   = iss && instr.op == swrs_pkg::SWRS_OP_WIDEN_VAR;
  assign rt   = iss && instr.op == swrs_pkg::SWRS_OP_RIGHT;
  assign wtop = instr.shift_field_six_bit[5:3] != 3'h0;
  assign rtop = instr.long_bit || wtop;
  assign odd  = instr.dest_register_index[0];
  // Refusal by access control may override any decode outcome
  assign refd = result_kind inside {swrs_pkg::SWRS_RES_UNDEF,
                                    swrs_pkg::SWRS_RES_TRAP};
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_done_latency: assert property (iss |=> done)
    else $error("done missing after issue");
  a_done_cause: assert property (!iss |=> !done)
    else $error("done without issue");
  a_wide_related: assert property (wv && !wtop |=> refd ||
    result_kind == swrs_pkg::SWRS_RES_RELATED) else $error("wide related");
  a_wide_odd: assert property (wv && wtop && odd |=> refd)
    else $error("odd widening destination accepted");
  a_wide_move: assert property (wv && !odd &&
    instr.shift_field_six_bit inside {6'h08, 6'h10, 6'h20} |=>
    refd || result_kind == swrs_pkg::SWRS_RES_WMOVE) else $error("wmove");
  a_max_undef: assert property (iss &&
    instr.op == swrs_pkg::SWRS_OP_WIDEN_MAX &&
    (instr.size_field == swrs_pkg::SIZE_BAD || odd) |=> refd)
    else $error("bad maximum form accepted");
  a_right_related: assert property (rt && !rtop |=> refd ||
    result_kind == swrs_pkg::SWRS_RES_RELATED) else $error("right related");
  a_right_odd: assert property (rt && rtop && instr.quad_bit &&
    (odd || instr.source_register_index[0]) |=> refd)
    else $error("odd quad index accepted");
  a_apb_wait: assert property ($rose(penable) && psel |-> s_answer)
    else $error("ready not in second access cycle");
endmodule

// ### dv/swrs_decode_model.sv
// Decode-stage model: presents one instruction per call.
// Assumes the unit takes valid with cond_pass at a rising edge.
`timescale 1ns/1ps
module swrs_decode_model (
  // Clock
  input  wire logic             pclk,
  // Instruction to the unit
  output swrs_pkg::swrs_instr_s instr
);
  initial instr = '0;
  // Idle fields carry the inverse so a stale read shows up
  task automatic issue(input swrs_pkg::swrs_instr_s i);
    swrs_pkg::swrs_instr_s idle;
    idle = ~i;
    idle.valid = 1'h0;
    @(posedge pclk);
    instr <= i;
    @(posedge pclk);
    instr <= idle;
  endtask
endmodule

// ### dv/testbench.sv
// Testbench: registers, both shifts and refused encodings.
// Assumes the decode model issues; checker bound at the foot.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic                  pclk = 1'h0;
  logic                  presetn, psel, penable, pwrite, pready, pslverr;
  logic                  done, err;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [63:0]           lo, hi, keep;
  swrs_pkg::swrs_instr_s instr;
  swrs_pkg::swrs_res_e   result_kind;
  int                    miscompares = 0;
  int                    n_tests = 0;
  localparam logic [63:0] SA = 64'hF0E1_D2C3_B4A5_9687;
  localparam logic [63:0] SB = 64'h0123_8899_7F00_FF80;
  always #2 pclk = ~pclk;
  swrs_shift_unit i_swrs_shift_unit (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr(instr), .done(done), .result_kind(result_kind));
  swrs_decode_model i_swrs_decode_model (.pclk(pclk), .instr(instr));
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    for (k = 0; pready !== 1'h1 && k < 20; k++)
      @(posedge pclk);
    if (k >= 20)
    begin
      miscompares++;
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task setd(input logic [4:0] i, input logic [63:0] v);
    apb(1'h1, swrs_pkg::OFF_INDEX, 32'(i));
    apb(1'h1, swrs_pkg::OFF_DLO, v[31:0]);
    apb(1'h1, swrs_pkg::OFF_DHI, v[63:32]);
  endtask
  task getd(input logic [4:0] i, output logic [63:0] v);
    apb(1'h1, swrs_pkg::OFF_INDEX, 32'(i));
    apb(1'h0, swrs_pkg::OFF_DLO, 32'h0);
    v[31:0] = rd;
    apb(1'h0, swrs_pkg::OFF_DHI, 32'h0);
    v[63:32] = rd;
  endtask
  task exe(input swrs_pkg::swrs_op_e op, input logic [4:0] d, m,
           input logic u, q, l, input logic [5:0] f, input logic [1:0] sz,
           input swrs_pkg::swrs_res_e k);
    swrs_pkg::swrs_instr_s i;
    i = '0;
    i.valid = 1'h1;
    i.cond_pass = 1'h1;
    i.op = op;
    i.unsigned_bit = u;
    {i.d_hi, i.dest_register_index} = d;
    {i.m_hi, i.source_register_index} = m;
    i.quad_bit = q;
    i.long_bit = l;
    i.shift_field_six_bit = f;
    i.size_field = sz;
    i.condition_flags = f[3:0];
    i_swrs_decode_model.issue(i);
    #1;
    `CHK(done, 1'h1)
    `CHK(result_kind, k)
  endtask
  function automatic logic [127:0] ext(logic [63:0] s, int e, es, logic u);
    logic [127:0] m;
    logic [127:0] x;
    m = (128'h1 << es) - 1;
    x = (128'(s) >> (e * es)) & m;
    if (!u && x[es-1])
      x = x | ~m;
    return x;
  endfunction
  function automatic logic [127:0] wide(logic [63:0] s, int es, sh,
                                        logic u);
    logic [127:0] r;
    r = '0;
    for (int e = 0; e < 64 / es; e++)
      r = r | (((ext(s, e, es, u) << sh) & ((128'h1 << 2 * es) - 1))
               << (2 * e * es));
    return r;
  endfunction
  function automatic logic [63:0] rsh(logic [63:0] s, int es, sh, logic u);
    logic signed [127:0] t;
    logic [127:0]        r;
    r = '0;
    for (int e = 0; e < 64 / es; e++)
    begin
      t = ext(s, e, es, u);
      t = t >>> sh;
      r = r | ((t & ((128'h1 << es) - 1)) << (e * es));
    end
    return r[63:0];
  endfunction
  task t_regs;
    apb(1'h0, swrs_pkg::OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h0, 12'h020, 32'h0);
    `CHK(err, 1'h1)
    exe(swrs_pkg::SWRS_OP_WIDEN_VAR, 4, 2, 0, 0, 0, 6'h0b, 0,
        swrs_pkg::SWRS_RES_UNDEF);
    apb(1'h1, swrs_pkg::OFF_CTRL, 32'h3);
    exe(swrs_pkg::SWRS_OP_RIGHT, 4, 2, 0, 0, 0, 6'h0b, 0,
        swrs_pkg::SWRS_RES_TRAP);
    apb(1'h1, swrs_pkg::OFF_CTRL, 32'h1);
    setd(2, SA);
    setd(3, SB);
    $display("test regs ended");
  endtask
  task t_widen;
    int es, sh;
    for (int s = 0; s < 3; s++)
      for (int u = 0; u < 2; u++)
      begin
        es = 8 << s;
        sh = u ? es - 1 : 1;
        exe(swrs_pkg::SWRS_OP_WIDEN_VAR, 4, 2, u, 0, 0, 6'(es + sh), 0,
            swrs_pkg::SWRS_RES_EXEC);
        getd(4, lo);
        getd(5, hi);
        `CHK({hi, lo}, wide(SA, es, sh, u))
        exe(swrs_pkg::SWRS_OP_WIDEN_MAX, 6, 2, u, 0, 0, 0, 2'(s),
            swrs_pkg::SWRS_RES_EXEC);
        getd(6, lo);
        getd(7, hi);
        `CHK({hi, lo}, wide(SA, es, es, 0))
      end
    $display("test widen ended");
  endtask
  task t_right;
    int es, sh;
    logic [6:0] c;
    for (int s = 0; s < 4; s++)
      for (int u = 0; u < 2; u++)
      begin
        es = 8 << s;
        sh = u ? es : 1;
        c = 7'(2 * es - sh);
        exe(swrs_pkg::SWRS_OP_RIGHT, 8, 2, u, 1, c[6], c[5:0], 0,
            swrs_pkg::SWRS_RES_EXEC);
        getd(8, lo);
        getd(9, hi);
        `CHK(lo, rsh(SA, es, sh, u))
        `CHK(hi, rsh(SB, es, sh, u))
      end
    $display("test right ended");
  endtask
  task t_refuse;
    getd(4, keep);
    exe(swrs_pkg::SWRS_OP_WIDEN_VAR, 5, 2, 0, 0, 0, 6'h05, 0,
        swrs_pkg::SWRS_RES_RELATED);
    exe(swrs_pkg::SWRS_OP_WIDEN_VAR, 4, 2, 1, 0, 0, 6'h10, 0,
        swrs_pkg::SWRS_RES_WMOVE);
    exe(swrs_pkg::SWRS_OP_WIDEN_VAR, 5, 2, 0, 0, 0, 6'h0b, 0,
        swrs_pkg::SWRS_RES_UNDEF);
    exe(swrs_pkg::SWRS_OP_WIDEN_MAX, 4, 2, 0, 0, 0, 0, 2'h3,
        swrs_pkg::SWRS_RES_UNDEF);
    exe(swrs_pkg::SWRS_OP_WIDEN_MAX, 5, 2, 0, 0, 0, 0, 2'h0,
        swrs_pkg::SWRS_RES_UNDEF);
    exe(swrs_pkg::SWRS_OP_RIGHT, 4, 2, 0, 0, 0, 6'h07, 0,
        swrs_pkg::SWRS_RES_RELATED);
    exe(swrs_pkg::SWRS_OP_RIGHT, 4, 3, 0, 1, 0, 6'h08, 0,
        swrs_pkg::SWRS_RES_UNDEF);
    apb(1'h0, swrs_pkg::OFF_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0001)
    getd(4, lo);
    `CHK(lo, keep)
    $display("test refuse ended");
  endtask
  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_widen;
    t_right;
    t_refuse;
    finish_test;
  end
endmodule
bind swrs_shift_unit swrs_shift_assertions #(.NREGS(NREGS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .instr(instr), .done(done),
  .result_kind(result_kind));
